// ===== rtl/vos_pkg.sv
package vos_pkg;

  // Register byte offsets
  localparam logic [5:0] VOS_OFS_CTRL   = 6'h00;
  localparam logic [5:0] VOS_OFS_DELAY  = 6'h04;
  localparam logic [5:0] VOS_OFS_PRESET = 6'h08;
  localparam logic [5:0] VOS_OFS_FLEN   = 6'h0c;
  localparam logic [5:0] VOS_OFS_LLEN   = 6'h10;
  localparam logic [5:0] VOS_OFS_MLEN   = 6'h14;
  localparam logic [5:0] VOS_OFS_STATUS = 6'h18;
  localparam logic [5:0] VOS_OFS_YBASE  = 6'h1c;
  localparam logic [5:0] VOS_OFS_UBASE  = 6'h20;
  localparam logic [5:0] VOS_OFS_VBASE  = 6'h24;
  localparam logic [5:0] VOS_OFS_STRIDE = 6'h28;
  localparam logic [5:0] VOS_OFS_OBASE  = 6'h2c;

  // Control field positions
  localparam int VOS_B_TSRC   = 0;
  localparam int VOS_B_ON     = 1;
  localparam int VOS_B_LOCK   = 2;
  localparam int VOS_B_POL    = 3;
  localparam int VOS_B_STREAM = 4;
  localparam int VOS_B_VFLAG  = 5;
  localparam int VOS_B_MSG    = 6;
  localparam int VOS_B_GO     = 7;
  localparam int VOS_B_FMT    = 8;
  localparam int VOS_B_SWAP   = 10;

  // Status field positions
  localparam int VOS_S_DRAIN  = 0;
  localparam int VOS_S_UNDER  = 1;
  localparam int VOS_S_LOCKED = 2;
  localparam int VOS_S_BUSY   = 3;
  localparam int VOS_S_LINE   = 16;

  // Reset values
  localparam logic [31:0] VOS_CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] VOS_DELAY_RST  = 16'h0000;
  localparam logic [15:0] VOS_PRESET_RST = 16'h0002;
  localparam logic [15:0] VOS_FLEN_RST   = 16'h020d;
  localparam logic [15:0] VOS_LLEN_RST   = 16'h0100;
  localparam logic [15:0] VOS_MLEN_RST   = 16'h0000;
  localparam logic [15:0] VOS_COUNT_ONE  = 16'h0001;

  typedef enum logic [1:0] {
    VOS_IDLE  = 2'b00,
    VOS_START = 2'b01,
    VOS_SEND  = 2'b11,
    VOS_END   = 2'b10
  } vos_xfer_t;

  typedef enum logic [1:0] {
    VOS_FMT_422C = 2'b00,
    VOS_FMT_422I = 2'b01,
    VOS_FMT_420  = 2'b10
  } vos_fmt_t;

endpackage

// ===== rtl/vos_sync_edge.sv
`timescale 1ns/1ps
module vos_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Foreign level and its edges
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;
endmodule

// ===== rtl/vos_fetch_addr.sv
`timescale 1ns/1ps
module vos_fetch_addr (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Position and layout
  input  wire logic        step,
  input  wire logic [15:0] line,
  input  wire logic [15:0] pix,
  input  wire logic [1:0]  fmt,
  input  wire logic        swap,
  // Table bases
  input  wire logic [31:0] y_base,
  input  wire logic [31:0] u_base,
  input  wire logic [31:0] v_base,
  input  wire logic [15:0] stride,
  input  wire logic [31:0] ovl_base,
  // Overlay pixel word
  input  wire logic [15:0] ovl_word_in,
  // Fetch results
  output logic [31:0]      y_addr,
  output logic [31:0]      u_addr,
  output logic [31:0]      v_addr,
  output logic [31:0]      ovl_addr,
  output logic [15:0]      ovl_word_out
);
  import vos_pkg::*;

  logic [15:0] img_line;
  logic [15:0] img_pix;
  logic [15:0] c_line;
  logic [15:0] c_pix;
  logic [15:0] c_stride;

  assign img_line = line - VOS_COUNT_ONE;
  assign img_pix  = pix - VOS_COUNT_ONE;
  // Chroma tables are half width in every layout
  assign c_pix    = {1'b0, img_pix[15:1]};
  assign c_stride = {1'b0, stride[15:1]};
  // 4:2:0 chroma also has half the lines
  assign c_line   = (fmt == VOS_FMT_420) ?
                    {1'b0, img_line[15:1]} : img_line;

  // Same table walk for co-sited and interspersed; chroma filter is later
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      y_addr <= 32'h0000_0000;
      u_addr <= 32'h0000_0000;
      v_addr <= 32'h0000_0000;
    end else if (step) begin
      y_addr <= y_base + img_line * stride + 32'(img_pix);
      u_addr <= u_base + c_line * c_stride + 32'(c_pix);
      v_addr <= v_base + c_line * c_stride + 32'(c_pix);
    end
  end

  // Overlay walks output pixels, two bytes each, with no upscale step
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ovl_addr     <= 32'h0000_0000;
      ovl_word_out <= 16'h0000;
    end else if (step) begin
      ovl_addr <= ovl_base + img_line * stride * 32'h2
                  + {15'h0000, img_pix, 1'b0};
      ovl_word_out <= swap ? {ovl_word_in[7:0], ovl_word_in[15:8]}
                           : ovl_word_in;
    end
  end
endmodule

// ===== rtl/vos_video_out.sv
// Overview of operation
// - Slave timing only when internal timing off, unit on and lock selected.
// - A control bit picks which frame sync edge is active.
// - First synchronising edge loads the frame line counter with the preload.
// - Line counter wraps to 1 after reaching the frame line total.
// - Active sync edge is delayed by the programmed count of link clocks.
// - Before the first sync edge, counters run free on programmed timing.
// - Output may glitch briefly after sync; the next frame is correct.
// - A matching later edge changes nothing; a mismatch resynchronises.
// - Stream mode, which also needs the valid flag bit, sends raw bytes, one per link clock, on rising edge.
// - Streaming valid flag frames the bytes, drops on end or underrun.
// - Line strobe pulses one link clock before the first valid byte.
// - Setting transfer go in message mode signals a start on line strobe.
// - Message end signals on frame sync, sets drained flag, raises event.
// - After a message the unit idles until transfer go is set again.
// - Images fetch in 4:2:2 co-sited, 4:2:2 interspersed or 4:2:0.
// - 4:2:2 planar chroma tables: same lines, half pixels of luma.
// - 4:2:0 planar chroma tables: half lines and half pixels.
// - Overlay is packed 4:2:2 plus alpha and never upscaled.
// - Each overlay pixel is one 16-bit word with 16-bit byte order.
// - With internal timing selected, unit on and no transfer mode, the unit drives line and frame timing.
`timescale 1ns/1ps
module vos_video_out (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM register slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Video link pins
  input  wire logic        video_out_clock,
  output logic [7:0]       video_byte_bus,
  output logic             line_strobe_pin,
  input  wire logic        frame_sync_i,
  output logic             frame_sync_o,
  output logic             frame_sync_oe,
  // Byte source
  input  wire logic [7:0]  src_byte,
  input  wire logic        src_valid,
  output logic             src_ready,
  // Memory fetch side
  input  wire logic [15:0] ovl_word_in,
  output logic [15:0]      ovl_word_out,
  output logic [31:0]      y_addr,
  output logic [31:0]      u_addr,
  output logic [31:0]      v_addr,
  output logic [31:0]      ovl_addr,
  // Message done event to host core
  output logic             host_event
);
  import vos_pkg::*;

  logic [31:0] ctrl_reg;
  logic [15:0] delay_reg;
  logic [15:0] preset_reg;
  logic [15:0] flen_reg;
  logic [15:0] llen_reg;
  logic [15:0] mlen_reg;
  logic [31:0] ybase_reg;
  logic [31:0] ubase_reg;
  logic [31:0] vbase_reg;
  logic [15:0] stride_reg;
  logic [31:0] obase_reg;
  logic        drained_reg;
  logic        under_reg;
  logic        locked_reg;
  logic        go_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [15:0] line_reg;
  logic [15:0] pix_reg;
  logic [15:0] dly_cnt_reg;
  logic        dly_run_reg;
  vos_xfer_t   state_reg;
  logic [15:0] mcnt_reg;
  logic        strobe_reg;
  logic        mark_reg;
  logic [7:0]  byte_reg;
  logic        ready_reg;
  logic        ls_pin_reg;
  logic        fs_pin_reg;
  logic        fs_oe_reg;
  logic        event_reg;

  logic        tick;
  logic        fs_rise;
  logic        fs_fall;
  logic        wr_en;
  logic        master;
  logic        unit_on;
  logic        slave_mode;
  logic        msg_mode;
  logic        stream_ok;
  logic        xfer_mode;
  logic        act_edge;
  logic        fire;
  logic        match;
  logic        take;
  logic        underrun;
  logic        msg_done;
  logic [15:0] line_next;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a[5:2] == o[5:2]);
  endfunction

  vos_sync_edge u_vclk (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (video_out_clock),
    .level    (),
    .rise     (tick),
    .fall     ()
  );

  vos_sync_edge u_fsync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (frame_sync_i),
    .level    (),
    .rise     (fs_rise),
    .fall     (fs_fall)
  );

  assign master     = ctrl_reg[VOS_B_TSRC];
  assign unit_on    = ctrl_reg[VOS_B_ON];
  assign msg_mode   = ctrl_reg[VOS_B_MSG];
  assign stream_ok  = ctrl_reg[VOS_B_STREAM] & unit_on
                      & ctrl_reg[VOS_B_VFLAG];
  assign xfer_mode  = stream_ok | msg_mode;
  assign slave_mode = ~master & unit_on & ctrl_reg[VOS_B_LOCK]
                      & ~xfer_mode;
  assign act_edge   = slave_mode &
                      (ctrl_reg[VOS_B_POL] ? fs_rise : fs_fall);

  // Bus slave: one wait cycle, then the access completes
  assign wr_en = avs_write & ~wait_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wait_reg <= 1'b1;
    end else if ((avs_read | avs_write) & wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read & wait_reg) begin
      rdata_reg <= 32'h0000_0000;
      if (hit(avs_address, VOS_OFS_CTRL)) begin
        rdata_reg <= ctrl_reg;
      end
      if (hit(avs_address, VOS_OFS_DELAY)) begin
        rdata_reg <= {16'h0000, delay_reg};
      end
      if (hit(avs_address, VOS_OFS_PRESET)) begin
        rdata_reg <= {16'h0000, preset_reg};
      end
      if (hit(avs_address, VOS_OFS_FLEN)) begin
        rdata_reg <= {16'h0000, flen_reg};
      end
      if (hit(avs_address, VOS_OFS_LLEN)) begin
        rdata_reg <= {16'h0000, llen_reg};
      end
      if (hit(avs_address, VOS_OFS_MLEN)) begin
        rdata_reg <= {16'h0000, mlen_reg};
      end
      if (hit(avs_address, VOS_OFS_STATUS)) begin
        rdata_reg[VOS_S_DRAIN]  <= drained_reg;
        rdata_reg[VOS_S_UNDER]  <= under_reg;
        rdata_reg[VOS_S_LOCKED] <= locked_reg;
        rdata_reg[VOS_S_BUSY]   <= (state_reg != VOS_IDLE) | go_reg;
        rdata_reg[VOS_S_LINE +: 16] <= line_reg;
      end
      if (hit(avs_address, VOS_OFS_YBASE)) begin
        rdata_reg <= ybase_reg;
      end
      if (hit(avs_address, VOS_OFS_UBASE)) begin
        rdata_reg <= ubase_reg;
      end
      if (hit(avs_address, VOS_OFS_VBASE)) begin
        rdata_reg <= vbase_reg;
      end
      if (hit(avs_address, VOS_OFS_STRIDE)) begin
        rdata_reg <= {16'h0000, stride_reg};
      end
      if (hit(avs_address, VOS_OFS_OBASE)) begin
        rdata_reg <= obase_reg;
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  // Timing registers are shared with master operation
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg   <= VOS_CTRL_RST;
      delay_reg  <= VOS_DELAY_RST;
      preset_reg <= VOS_PRESET_RST;
      flen_reg   <= VOS_FLEN_RST;
      llen_reg   <= VOS_LLEN_RST;
      mlen_reg   <= VOS_MLEN_RST;
      ybase_reg  <= 32'h0000_0000;
      ubase_reg  <= 32'h0000_0000;
      vbase_reg  <= 32'h0000_0000;
      stride_reg <= 16'h0000;
      obase_reg  <= 32'h0000_0000;
    end else if (wr_en) begin
      if (hit(avs_address, VOS_OFS_CTRL)) begin
        ctrl_reg <= avs_writedata & ~(32'h1 << VOS_B_GO);
      end
      if (hit(avs_address, VOS_OFS_DELAY)) begin
        delay_reg <= avs_writedata[15:0];
      end
      if (hit(avs_address, VOS_OFS_PRESET)) begin
        preset_reg <= avs_writedata[15:0];
      end
      if (hit(avs_address, VOS_OFS_FLEN)) begin
        flen_reg <= avs_writedata[15:0];
      end
      if (hit(avs_address, VOS_OFS_LLEN)) begin
        llen_reg <= avs_writedata[15:0];
      end
      if (hit(avs_address, VOS_OFS_MLEN)) begin
        mlen_reg <= avs_writedata[15:0];
      end
      if (hit(avs_address, VOS_OFS_YBASE)) begin
        ybase_reg <= avs_writedata;
      end
      if (hit(avs_address, VOS_OFS_UBASE)) begin
        ubase_reg <= avs_writedata;
      end
      if (hit(avs_address, VOS_OFS_VBASE)) begin
        vbase_reg <= avs_writedata;
      end
      if (hit(avs_address, VOS_OFS_STRIDE)) begin
        stride_reg <= avs_writedata[15:0];
      end
      if (hit(avs_address, VOS_OFS_OBASE)) begin
        obase_reg <= avs_writedata;
      end
    end
  end

  // Go is a request latch, consumed when the message starts
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      go_reg <= 1'b0;
    end else if (wr_en & hit(avs_address, VOS_OFS_CTRL)
                 & avs_writedata[VOS_B_GO] & avs_writedata[VOS_B_MSG]) begin
      go_reg <= 1'b1;
    end else if (tick & (state_reg == VOS_IDLE) & stream_ok == 1'b0
                 & msg_mode) begin
      go_reg <= 1'b0;
    end
  end

  // Sticky flags: hardware set beats a same-cycle write-one clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drained_reg <= 1'b0;
      under_reg   <= 1'b0;
    end else begin
      if (msg_done) begin
        drained_reg <= 1'b1;
      end else if (wr_en & hit(avs_address, VOS_OFS_STATUS)
                   & avs_writedata[VOS_S_DRAIN]) begin
        drained_reg <= 1'b0;
      end
      if (underrun) begin
        under_reg <= 1'b1;
      end else if (wr_en & hit(avs_address, VOS_OFS_STATUS)
                   & avs_writedata[VOS_S_UNDER]) begin
        under_reg <= 1'b0;
      end
    end
  end

  // Frame counters, free running until a sync edge lands
  assign line_next = (line_reg == flen_reg) ? VOS_COUNT_ONE
                     : line_reg + VOS_COUNT_ONE;
  assign fire  = tick & dly_run_reg & (dly_cnt_reg == 16'h0000);
  assign match = locked_reg & (pix_reg == llen_reg)
                 & (line_next == preset_reg);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dly_run_reg <= 1'b0;
      dly_cnt_reg <= 16'h0000;
    end else if (act_edge) begin
      dly_run_reg <= 1'b1;
      dly_cnt_reg <= delay_reg;
    end else if (!slave_mode | fire) begin
      dly_run_reg <= 1'b0;
    end else if (tick & dly_run_reg) begin
      dly_cnt_reg <= dly_cnt_reg - VOS_COUNT_ONE;
    end
  end

  // A reload can cut a line short; the next frame is whole again
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_reg <= VOS_COUNT_ONE;
      pix_reg  <= VOS_COUNT_ONE;
    end else if (!unit_on) begin
      line_reg <= VOS_COUNT_ONE;
      pix_reg  <= VOS_COUNT_ONE;
    end else if (fire & !match) begin
      line_reg <= preset_reg;
      pix_reg  <= VOS_COUNT_ONE;
    end else if (tick) begin
      if (pix_reg == llen_reg) begin
        pix_reg  <= VOS_COUNT_ONE;
        line_reg <= line_next;
      end else begin
        pix_reg <= pix_reg + VOS_COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      locked_reg <= 1'b0;
    end else if (!slave_mode) begin
      locked_reg <= 1'b0;
    end else if (fire) begin
      locked_reg <= 1'b1;
    end
  end

  // Byte transfer engine, stepping once per link clock
  assign take     = tick & ready_reg & src_valid;
  assign underrun = tick & (state_reg == VOS_SEND) & ~src_valid
                    & (stream_ok | (mcnt_reg != mlen_reg));
  assign msg_done = tick & (state_reg == VOS_END);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg  <= VOS_IDLE;
      mcnt_reg   <= 16'h0000;
      strobe_reg <= 1'b0;
      mark_reg   <= 1'b0;
      ready_reg  <= 1'b0;
    end else if (tick) begin
      unique case (state_reg)
        VOS_IDLE: begin
          mark_reg <= 1'b0;
          if (stream_ok | (msg_mode & go_reg)) begin
            state_reg  <= VOS_START;
            strobe_reg <= 1'b1;
            ready_reg  <= 1'b1;
            mcnt_reg   <= 16'h0000;
          end
        end
        VOS_START: begin
          strobe_reg <= 1'b0;
          if (src_valid) begin
            state_reg <= VOS_SEND;
            mark_reg  <= stream_ok;
            mcnt_reg  <= VOS_COUNT_ONE;
            ready_reg <= stream_ok | (mlen_reg != VOS_COUNT_ONE);
          end
        end
        VOS_SEND: begin
          if (stream_ok) begin
            if (!src_valid) begin
              state_reg <= VOS_IDLE;
              mark_reg  <= 1'b0;
              ready_reg <= 1'b0;
            end
          end else if (msg_mode & (mcnt_reg == mlen_reg)) begin
            state_reg <= VOS_END;
            mark_reg  <= 1'b1;
            ready_reg <= 1'b0;
          end else if (!src_valid | !msg_mode) begin
            state_reg <= VOS_IDLE;
            mark_reg  <= 1'b0;
            ready_reg <= 1'b0;
          end else begin
            mcnt_reg <= mcnt_reg + VOS_COUNT_ONE;
            ready_reg <= (mcnt_reg + VOS_COUNT_ONE) != mlen_reg;
          end
        end
        VOS_END: begin
          state_reg <= VOS_IDLE;
          mark_reg  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      byte_reg <= 8'h00;
    end else if (take & (state_reg != VOS_END)) begin
      byte_reg <= src_byte;
    end
  end

  // Pin stage: transfer markers or internally made timing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ls_pin_reg <= 1'b0;
      fs_pin_reg <= 1'b0;
      fs_oe_reg  <= 1'b0;
      event_reg  <= 1'b0;
    end else begin
      event_reg <= drained_reg;
      if (xfer_mode) begin
        ls_pin_reg <= strobe_reg;
        fs_pin_reg <= mark_reg;
        fs_oe_reg  <= 1'b1;
      end else if (master & unit_on) begin
        ls_pin_reg <= (pix_reg == VOS_COUNT_ONE);
        fs_pin_reg <= (line_reg == VOS_COUNT_ONE);
        fs_oe_reg  <= 1'b1;
      end else begin
        ls_pin_reg <= 1'b0;
        fs_pin_reg <= 1'b0;
        fs_oe_reg  <= 1'b0;
      end
    end
  end

  assign video_byte_bus  = byte_reg;
  assign line_strobe_pin = ls_pin_reg;
  assign frame_sync_o    = fs_pin_reg;
  assign frame_sync_oe   = fs_oe_reg;
  assign src_ready       = ready_reg;
  assign host_event      = event_reg;

  vos_fetch_addr u_fetch (
    .clk          (clk),
    .reset_n      (reset_n),
    .step         (tick & unit_on),
    .line         (line_reg),
    .pix          (pix_reg),
    .fmt          (ctrl_reg[VOS_B_FMT +: 2]),
    .swap         (ctrl_reg[VOS_B_SWAP]),
    .y_base       (ybase_reg),
    .u_base       (ubase_reg),
    .v_base       (vbase_reg),
    .stride       (stride_reg),
    .ovl_base     (obase_reg),
    .ovl_word_in  (ovl_word_in),
    .y_addr       (y_addr),
    .u_addr       (u_addr),
    .v_addr       (v_addr),
    .ovl_addr     (ovl_addr),
    .ovl_word_out (ovl_word_out)
  );
endmodule

// ===== test/vos_monitor.sv
`timescale 1ns/1ps
module vos_monitor (
  // Watched ports
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  video_byte_bus,
  input wire logic        line_strobe_pin,
  input wire logic        frame_sync_o,
  input wire logic [15:0] ovl_word_in,
  input wire logic [15:0] ovl_word_out,
  input wire logic        host_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] ovl_prev;
  always_ff @(posedge clk) ovl_prev <= ovl_word_in;
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_wait_idle;
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer w/o request");
  property p_hole;
    avs_read && !avs_waitrequest && avs_address[5:2] > 4'hb
      |-> avs_readdata == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("hole read not zero");
  property p_strobe_wide;
    $rose(line_strobe_pin) |=> line_strobe_pin [*8];
  endproperty
  a_strobe_wide: assert property (p_strobe_wide) else $error("strobe short");
  property p_byte_hold;
    $changed(video_byte_bus) |=> $stable(video_byte_bus) [*8];
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte too short");
  property p_end_mark;
    $rose(host_event) |-> $past(frame_sync_o) || $past(frame_sync_o, 2)
      || $past(frame_sync_o, 3) || $past(frame_sync_o, 4);
  endproperty
  a_end_mark: assert property (p_end_mark) else $error("no end mark");
  property p_ovl_word;
    $changed(ovl_word_out) |-> ovl_word_out == ovl_prev
      || ovl_word_out == {ovl_prev[7:0], ovl_prev[15:8]};
  endproperty
  a_ovl_word: assert property (p_ovl_word) else $error("overlay word bad");
  c_strobe: cover property ($rose(line_strobe_pin));
  c_event: cover property ($rose(host_event));
  c_sync: cover property ($rose(frame_sync_o));
endmodule

// ===== test/vos_partner.sv
`timescale 1ns/1ps
module vos_partner (
  // Link side
  output logic       lclk,
  output logic       sync_pin,
  output logic [7:0] src_byte,
  output logic       src_valid,
  // Bench control
  input  wire logic  starve,
  input  wire logic  sync_req
);
  // Free link clock, phase unrelated to clk
  initial begin
    lclk = 1'b0;
    sync_pin = 1'b0;
    src_byte = 8'h00;
    src_valid = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end
  // Fresh byte each link clock so every take is visible
  always @(posedge lclk) begin
    src_byte <= src_byte + 8'h01;
    src_valid <= !starve;
    sync_pin <= sync_req;
  end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import vos_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [15:0] ovl_word_in = 16'h0;
  logic        starve = 1'b1;
  logic        sync_req = 1'b0;
  logic        strm = 1'b0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, lclk, line_strobe_pin, frame_sync_o;
  wire         frame_sync_oe, sync_pin, src_valid, src_ready, host_event;
  wire  [7:0]  video_byte_bus, src_byte;
  wire  [15:0] ovl_word_out;
  wire         frame_sync_i = frame_sync_oe ? frame_sync_o : sync_pin;
  int          n_errors = 0, num_checks = 0, nb = 0, sc = 0, ns = 0;
  logic        ls_q = 1'b0, fs_q = 1'b0, he_q = 1'b0;
  logic [7:0]  bb_q = 8'h00;
  logic [31:0] mq[$], eq[$], bq[$], rv;
  always #2.5 clk = ~clk;
  vos_video_out u_dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .video_out_clock(lclk),
    .video_byte_bus(video_byte_bus), .line_strobe_pin(line_strobe_pin),
    .frame_sync_i(frame_sync_i), .frame_sync_o(frame_sync_o),
    .frame_sync_oe(frame_sync_oe), .src_byte(src_byte),
    .src_valid(src_valid), .src_ready(src_ready),
    .ovl_word_in(ovl_word_in), .ovl_word_out(ovl_word_out), .y_addr(),
    .u_addr(), .v_addr(), .ovl_addr(), .host_event(host_event));
  vos_partner u_far (.lclk(lclk), .sync_pin(sync_pin), .src_byte(src_byte),
    .src_valid(src_valid), .starve(starve), .sync_req(sync_req));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo();
    n_errors++;
    $display("MISMATCH t=%0t wait ran out", $time);
    finish_test();
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) tmo();
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, e);
    mq.push_back(m);
    eq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_for(input int k);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((k == 0 ? host_event : frame_sync_o ^ (k == 2)) !== 1'b1
               && n < 3000);
    if (n >= 3000) tmo();
  endtask
  task automatic step_line(output logic [15:0] v);
    logic [15:0] old;
    int n;
    n = 0;
    bus(1'b0, VOS_OFS_STATUS, 32'h0);
    old = rv[31:16];
    do begin
      bus(1'b0, VOS_OFS_STATUS, 32'h0);
      n++;
    end while (rv[31:16] === old && n < 3000);
    if (n >= 3000) tmo();
    v = rv[31:16];
  endtask
  // Watcher: settled values at the falling edge
  always @(negedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && mq.size() > 0)
      chk(avs_readdata & mq.pop_front(), eq.pop_front());
    sc++;
    if (line_strobe_pin && !ls_q) begin
      nb = 0;
      sc = 0;
      ns++;
    end
    if (video_byte_bus !== bb_q) begin
      if (nb > 0) chk(video_byte_bus, bb_q + 8'h01);
      nb++;
    end
    if (frame_sync_o && !fs_q && strm) chk(sc == 12 || sc == 13, 1);
    if (host_event && !he_q) chk(nb, bq.pop_front());
    ls_q = line_strobe_pin;
    fs_q = frame_sync_o;
    he_q = host_event;
    bb_q = video_byte_bus;
  end
  initial begin
    logic [15:0] v;
    int k;
    void'($urandom(8998));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    ovl_word_in <= 16'($urandom);
    v = 16'($urandom);
    rd(VOS_OFS_CTRL, '1, VOS_CTRL_RST);
    rd(VOS_OFS_PRESET, '1, {16'h0, VOS_PRESET_RST});
    rd(VOS_OFS_FLEN, '1, {16'h0, VOS_FLEN_RST});
    rd(VOS_OFS_LLEN, '1, {16'h0, VOS_LLEN_RST});
    rd(6'h30, '1, 32'h0);
    bus(1'b1, VOS_OFS_DELAY, {16'h0, v});
    rd(VOS_OFS_DELAY, '1, {16'h0, v});
    $display("test regs done");
    starve <= 1'b0;
    v = 16'($urandom_range(4, 1));
    bq.push_back(32'(v));
    bus(1'b1, VOS_OFS_MLEN, {16'h0, v});
    bus(1'b1, VOS_OFS_CTRL, 32'hc2);
    wait_for(0);
    chk(src_ready, 1'b0);
    rd(VOS_OFS_STATUS, 32'h1, 32'h1);
    k = ns;
    bus(1'b1, VOS_OFS_STATUS, 32'h1);
    rd(VOS_OFS_STATUS, 32'h1, 32'h0);
    chk(ns, k);
    $display("test message done");
    bus(1'b1, VOS_OFS_CTRL, 32'h0);
    strm <= 1'b1;
    bus(1'b1, VOS_OFS_CTRL, 32'h32);
    wait_for(1);
    repeat (40) @(posedge clk);
    starve <= 1'b1;
    wait_for(2);
    rd(VOS_OFS_STATUS, 32'h2, 32'h2);
    bus(1'b1, VOS_OFS_CTRL, 32'h0);
    strm <= 1'b0;
    $display("test stream done");
    bus(1'b1, VOS_OFS_PRESET, 32'h5);
    bus(1'b1, VOS_OFS_FLEN, 32'h6);
    bus(1'b1, VOS_OFS_DELAY, 32'h3);
    bus(1'b1, VOS_OFS_CTRL, 32'h0e);
    sync_req <= 1'b1;
    step_line(v);
    chk(v, 16'h5);
    rd(VOS_OFS_STATUS, 32'h4, 32'h4);
    step_line(v);
    chk(v, 16'h6);
    step_line(v);
    chk(v, 16'h1);
    chk(ovl_word_out, ovl_word_in);
    $display("test slave done");
    finish_test();
  end
endmodule
bind vos_video_out vos_monitor u_mon (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .video_byte_bus(video_byte_bus), .line_strobe_pin(line_strobe_pin),
  .frame_sync_o(frame_sync_o), .ovl_word_in(ovl_word_in),
  .ovl_word_out(ovl_word_out), .host_event(host_event));
